//--- hw/tcd_pkg.sv
// Constants, field widths and command encodings of the transmit channel descriptor table
package tcd_pkg;
	localparam int PTR_W   = 15;                // Descriptor offsets
	localparam int BYTES_W = 16;                // Remaining byte count
	localparam int ADDR_W  = 32;                // Buffer dword address
	localparam int CNT_W   = 3;                 // Bytes taken per buffer access
	localparam int NUM_CHAN_DEF = 672;
	localparam logic [BYTES_W-1:0] BYTES_DONE = 16'h0000;
	localparam logic [ADDR_W-1:0]  ADDR_STEP  = 32'h0000_0001;
	localparam logic [PTR_W-1:0]   PTR_RST    = 15'h0000;
	localparam logic               FLAG_RST   = 1'b0;
	localparam logic               PRI_HIGH   = 1'b1;
	localparam logic               PRI_LOW    = 1'b0;

	typedef enum logic [9:0]
	{
		TCD_OP_NONE      = 10'h000,
		TCD_OP_PROVISION = 10'h001,
		TCD_OP_APPEND    = 10'h002,
		TCD_OP_LOAD      = 10'h004,
		TCD_OP_ACCESS    = 10'h008,
		TCD_OP_ADVANCE   = 10'h010,
		TCD_OP_MALFORMED = 10'h020,
		TCD_OP_FREE      = 10'h040,
		TCD_OP_REQUEST   = 10'h080,
		TCD_OP_DONE      = 10'h100,
		TCD_OP_SPARE     = 10'h200
	} tcd_op_e;
endpackage : tcd_pkg

//--- hw/tcd_table.sv
// Transmit channel descriptor table: per channel and priority DMA list state
`timescale 1ns/10ps
module tcd_table
	import tcd_pkg::*;
#(
	parameter int NUM_CHAN = NUM_CHAN_DEF,
	parameter int CH_W     = 10
)
(
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic                 cmd_valid,
	input  wire tcd_op_e              cmd_op,
	input  wire logic [CH_W-1:0]      cmd_chan,
	input  wire logic                 cmd_pri,
	input  wire logic                 cmd_flag,
	input  wire logic [PTR_W-1:0]     cmd_ptr,
	input  wire logic [PTR_W-1:0]     cmd_link,
	input  wire logic [BYTES_W-1:0]   cmd_bytes,
	input  wire logic [ADDR_W-1:0]    cmd_addr,
	input  wire logic [CNT_W-1:0]     cmd_count,
	input  wire logic [3:0]           cmd_desc_flags,
	input  wire logic                 und_valid,
	input  wire logic [CH_W-1:0]      und_chan,
	input  wire logic                 und_pri,
	output logic                      link_valid,
	output logic [PTR_W-1:0]          link_tail,
	output logic [PTR_W-1:0]          link_ref,
	output logic                      append_refused,
	output logic                      grant_valid,
	output logic                      grant_pri,
	output logic                      grant_null_abort,
	output logic                      grant_empty,
	output logic                      st_provisioned,
	output logic                      st_nonempty,
	output logic                      st_multi_chain,
	output logic                      st_null_abort,
	output logic                      st_underflow,
	output logic                      st_in_progress,
	output logic [3:0]                st_desc_flags,
	output logic [PTR_W-1:0]          st_cur_ptr,
	output logic [PTR_W-1:0]          st_host_ptr,
	output logic [PTR_W-1:0]          st_last_ptr,
	output logic [PTR_W-1:0]          st_next_ptr,
	output logic [BYTES_W-1:0]        st_bytes,
	output logic [ADDR_W-1:0]         st_addr
);
	localparam int DEPTH = 2 * NUM_CHAN;
	localparam int IDX_W = CH_W + 1;
	if (NUM_CHAN < 1 || NUM_CHAN > (1 << CH_W))
	begin : g_bad_chan
		$error("NUM_CHAN does not fit CH_W");
	end
	// Entry index: channel in the upper bits, priority in bit 0
	function automatic logic [IDX_W-1:0] entry_idx(input logic [CH_W-1:0] ch, input logic pri);
		entry_idx = {ch, pri};
	endfunction : entry_idx
	// Flags held in reset vectors; wide fields kept in plain arrays
	logic [DEPTH-1:0]   prov, nonempty, multi, null_abort_pending, und, packet_in_progress;
	logic [3:0]         dflags   [DEPTH];
	logic [PTR_W-1:0]   cur_ptr  [DEPTH], host_ptr [DEPTH], last_ptr [DEPTH], next_ptr [DEPTH];
	logic [BYTES_W-1:0] bytes    [DEPTH];
	logic [ADDR_W-1:0]  addr     [DEPTH];
	logic               ch_ok, und_ok, wr_en, w_clr_und;
	logic               w_prov, w_ne, w_multi, w_na, w_pip;
	logic [IDX_W-1:0]   e, ue;
	logic [3:0]         w_dflags;
	logic [PTR_W-1:0]   w_cur, w_host, w_last, w_next, next_link_tail;
	logic [BYTES_W-1:0] w_bytes;
	logic [ADDR_W-1:0]  w_addr;
	logic               next_link_valid, next_append_refused, next_grant_valid;
	logic               next_grant_pri, next_grant_null_abort, next_grant_empty;
	// Decode the command and build the new contents of the addressed entry
	always_comb
	begin
		ch_ok  = int'(cmd_chan) < NUM_CHAN;
		und_ok = und_valid && (int'(und_chan) < NUM_CHAN);
		ue     = entry_idx(und_chan, und_pri);
		e      = entry_idx(cmd_chan, cmd_pri);
		if (cmd_op == TCD_OP_REQUEST)
		begin
			e = entry_idx(cmd_chan, nonempty[entry_idx(cmd_chan, PRI_HIGH)] ? PRI_HIGH : PRI_LOW);
		end
		wr_en     = cmd_valid && ch_ok;
		w_prov    = prov[e];
		w_ne      = nonempty[e];
		w_multi   = multi[e];
		w_na      = null_abort_pending[e];
		w_pip     = packet_in_progress[e];
		w_clr_und = 1'b0;
		w_dflags  = dflags[e];
		w_cur     = cur_ptr[e];
		w_host    = host_ptr[e];
		w_last    = last_ptr[e];
		w_next    = next_ptr[e];
		w_bytes   = bytes[e];
		w_addr    = addr[e];
		next_link_valid       = 1'b0;
		next_link_tail        = PTR_RST;
		next_append_refused   = 1'b0;
		next_grant_valid      = 1'b0;
		next_grant_pri        = e[0];
		next_grant_null_abort = 1'b0;
		next_grant_empty      = 1'b0;
		case (cmd_op)
			TCD_OP_PROVISION:
			begin
				// active flag; unprovisioning drops the list state
				w_prov = cmd_flag;
				{w_ne, w_multi, w_pip, w_na} = cmd_flag ? {w_ne, w_multi, w_pip, w_na} : 4'h0;
			end
			TCD_OP_APPEND:
			begin
				if (!prov[e])
				begin
					next_append_refused = 1'b1;
				end
				else if (!nonempty[e])
				begin
					w_ne  = 1'b1;
					w_cur = cmd_ptr;
				end
				else
				begin
					next_link_valid = 1'b1;
					next_link_tail  = multi[e] ? last_ptr[e] : cur_ptr[e];
					// second chain validates next and last
					w_next  = multi[e] ? next_ptr[e] : cmd_ptr;
					w_multi = 1'b1;
					w_last = cmd_ptr;
				end
			end
			TCD_OP_LOAD:
			begin
				// flag copies refreshed with new descriptor
				w_dflags = cmd_desc_flags;
				w_host  = cmd_link;
				w_bytes = cmd_bytes;
				w_addr  = cmd_addr;
				w_cur   = cmd_ptr;
			end
			TCD_OP_ACCESS:
			begin
				// decrement remaining count, stop at zero
				w_bytes = (w_bytes > BYTES_W'(cmd_count)) ? w_bytes - BYTES_W'(cmd_count)
					: BYTES_DONE;
				w_addr = w_addr + ADDR_STEP;
			end
			TCD_OP_ADVANCE:
			begin
				// only a fully read buffer advances
				if (bytes[e] == BYTES_DONE && nonempty[e])
				begin
					if (!dflags[e][0])
					begin
						w_cur = host_ptr[e];
					end
					else if (multi[e])
					begin
						w_cur   = next_ptr[e];
						w_multi = (next_ptr[e] != last_ptr[e]);
						w_next  = w_multi ? cmd_link : next_ptr[e];
					end
					else
					begin
						w_ne = 1'b0;
					end
				end
			end
			TCD_OP_MALFORMED:
			begin
				w_na = 1'b1;
			end
			TCD_OP_FREE:
			begin
				w_clr_und = 1'b1;
			end
			TCD_OP_REQUEST:
			begin
				next_grant_valid = 1'b1;
				if (null_abort_pending[e])
				begin
					next_grant_null_abort = 1'b1;
					w_na = 1'b0;
				end
				else if (!nonempty[e] || !prov[e])
				begin
					next_grant_empty = 1'b1;
				end
				else
				begin
					w_pip = 1'b1;
				end
			end
			TCD_OP_DONE:
			begin
				w_pip = 1'b0;
			end
			default:
			begin
				wr_en = 1'b0;
			end
		endcase
		if (!cmd_valid || !ch_ok)
		begin
			next_link_valid     = 1'b0;
			next_append_refused = 1'b0;
			next_grant_valid    = 1'b0;
		end
	end
	// Register the entry update, pulses and the status view
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			// Pointer, count and address arrays stay unreset: the flags mark them invalid
			{prov, nonempty, multi, null_abort_pending, und, packet_in_progress} <= '0;
			{link_valid, link_tail, link_ref, append_refused} <= '0;
			{grant_valid, grant_pri, grant_null_abort, grant_empty} <= '0;
			{st_provisioned, st_nonempty, st_multi_chain, st_null_abort} <= '0;
			{st_underflow, st_in_progress, st_desc_flags} <= '0;
			{st_cur_ptr, st_host_ptr, st_last_ptr, st_next_ptr} <= '0;
			{st_bytes, st_addr} <= '0;
		end
		else
		begin
			// each entry written on its own
			if (wr_en)
			begin
				prov[e]               <= w_prov;
				nonempty[e]           <= w_ne;
				multi[e]              <= w_multi;
				null_abort_pending[e] <= w_na;
				packet_in_progress[e] <= w_pip;
				dflags[e]             <= w_dflags;
				cur_ptr[e]            <= w_cur;
				host_ptr[e]           <= w_host;
				last_ptr[e]           <= w_last;
				next_ptr[e]           <= w_next;
				bytes[e]              <= w_bytes;
				addr[e]               <= w_addr;
				und[e]                <= und[e] && !w_clr_und;
			end
			// underflow set wins over same-cycle clear
			if (und_ok)
			begin
				und[ue] <= 1'b1;
			end
			link_valid       <= next_link_valid;
			link_tail        <= next_link_tail;
			link_ref         <= cmd_ptr;
			append_refused   <= next_append_refused;
			grant_valid      <= next_grant_valid;
			grant_pri        <= next_grant_pri;
			grant_null_abort <= next_grant_null_abort;
			grant_empty      <= next_grant_empty;
			// Status shows the addressed entry after this cycle's update
			st_provisioned   <= w_prov;
			st_nonempty      <= w_ne;
			st_multi_chain   <= w_multi;
			st_null_abort    <= w_na;
			st_underflow     <= (und[e] && !(wr_en && w_clr_und)) || (und_ok && ue == e);
			st_in_progress   <= w_pip;
			st_desc_flags    <= w_dflags;
			st_cur_ptr       <= w_cur;
			st_host_ptr      <= w_host;
			st_last_ptr      <= w_last;
			st_next_ptr      <= w_next;
			st_bytes         <= w_bytes;
			st_addr          <= w_addr;
		end
	end
endmodule : tcd_table

//--- bench/tcd_table_checker.sv
// Concurrent checks on the descriptor table ports
`timescale 1ns/10ps
module tcd_table_checker
	import tcd_pkg::*;
#(
	parameter int NUM_CHAN = 4,
	parameter int CH_W     = 3
)
(
	input wire logic               clk,
	input wire logic               nrst,
	input wire logic               cmd_valid,
	input wire tcd_op_e            cmd_op,
	input wire logic [CH_W-1:0]    cmd_chan,
	input wire logic               cmd_flag,
	input wire logic [PTR_W-1:0]   cmd_ptr,
	input wire logic [BYTES_W-1:0] cmd_bytes,
	input wire logic [3:0]         cmd_desc_flags,
	input wire logic               link_valid,
	input wire logic [PTR_W-1:0]   link_ref,
	input wire logic               grant_valid,
	input wire logic               st_provisioned,
	input wire logic               st_nonempty,
	input wire logic               st_multi_chain,
	input wire logic               st_null_abort,
	input wire logic               st_in_progress,
	input wire logic [3:0]         st_desc_flags,
	input wire logic [PTR_W-1:0]   st_cur_ptr,
	input wire logic [PTR_W-1:0]   st_last_ptr,
	input wire logic [BYTES_W-1:0] st_bytes
);
	logic taken;
	// Out of range channels are dropped, so they trigger nothing
	assign taken = cmd_valid && (32'(cmd_chan) < NUM_CHAN);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// One accepted command of a given kind
	sequence s_cmd(tcd_op_e op);
		taken && cmd_op == op;
	endsequence
	property p_grant;
		s_cmd(TCD_OP_REQUEST) |=> grant_valid;
	endproperty
	a_grant: assert property (p_grant) else $error("request not granted");
	property p_grant_src;
		grant_valid |-> $past(taken) && $past(cmd_op) == TCD_OP_REQUEST;
	endproperty
	a_grant_src: assert property (p_grant_src) else $error("grant without request");
	property p_prov;
		s_cmd(TCD_OP_PROVISION) |=> st_provisioned == $past(cmd_flag);
	endproperty
	a_prov: assert property (p_prov) else $error("active flag wrong");
	property p_unprov;
		s_cmd(TCD_OP_PROVISION) ##0 !cmd_flag |=> !st_nonempty && !st_multi_chain;
	endproperty
	a_unprov: assert property (p_unprov) else $error("list kept on inactive");
	property p_load;
		s_cmd(TCD_OP_LOAD) |=> st_cur_ptr == $past(cmd_ptr) && st_bytes == $past(cmd_bytes);
	endproperty
	a_load: assert property (p_load) else $error("load not stored");
	property p_flags;
		s_cmd(TCD_OP_LOAD) |=> st_desc_flags == $past(cmd_desc_flags);
	endproperty
	a_flags: assert property (p_flags) else $error("flag copies stale");
	property p_link;
		link_valid |-> link_ref == $past(cmd_ptr) && st_last_ptr == link_ref && st_multi_chain;
	endproperty
	a_link: assert property (p_link) else $error("append link wrong");
	property p_done;
		s_cmd(TCD_OP_DONE) |=> !st_in_progress;
	endproperty
	a_done: assert property (p_done) else $error("packet still in progress");
	property p_null;
		s_cmd(TCD_OP_MALFORMED) |=> st_null_abort;
	endproperty
	a_null: assert property (p_null) else $error("null abort not pending");
endmodule : tcd_table_checker

//--- bench/tcd_down.sv
// Downstream model: raises underflows and counts null aborts
`timescale 1ns/10ps
module tcd_down
	import tcd_pkg::*;
#(
	parameter int CH_W = 3
)
(
	input  wire logic            clk,
	input  wire logic            grant_valid,
	input  wire logic            grant_null_abort,
	output logic                 und_valid,
	output logic [CH_W-1:0]      und_chan,
	output logic                 und_pri
);
	int nulls;
	// Quiet lines from time zero
	initial
	begin
		nulls = 0;
		und_valid = 1'h0;
		und_chan = '0;
		und_pri = 1'h0;
	end
	// Null aborts seen on grants
	always @(posedge clk)
		if (grant_valid && grant_null_abort)
			nulls++;
	// One cycle pulse; channel inverted after so a stale value cannot match
	task flag_und(input logic [CH_W-1:0] ch, input logic pr);
		@(negedge clk);
		und_chan = ch;
		und_pri = pr;
		und_valid = 1'h1;
		@(negedge clk);
		und_valid = 1'h0;
		und_chan = ~ch;
	endtask : flag_und
endmodule : tcd_down

//--- bench/test_tcd_table.sv
// Directed test of the descriptor table with a downstream model
`timescale 1ns/10ps
module test_tcd_table
	import tcd_pkg::*;
	;
	localparam int NCH = 5;
	localparam int CW  = 3;
	logic clk, nrst, cmd_valid, cmd_pri, cmd_flag, und_valid, und_pri;
	logic link_valid, append_refused, grant_valid, grant_pri, grant_null_abort, grant_empty;
	logic st_provisioned, st_nonempty, st_multi_chain, st_null_abort, st_underflow;
	logic st_in_progress;
	tcd_op_e cmd_op;
	logic [CW-1:0] cmd_chan, und_chan;
	logic [PTR_W-1:0] cmd_ptr, cmd_link, link_tail, link_ref;
	logic [PTR_W-1:0] st_cur_ptr, st_host_ptr, st_last_ptr, st_next_ptr;
	logic [BYTES_W-1:0] cmd_bytes, st_bytes;
	logic [ADDR_W-1:0] cmd_addr, st_addr;
	logic [CNT_W-1:0] cmd_count;
	logic [3:0] cmd_desc_flags, st_desc_flags;
	int bad_count, n_compared;
	tcd_table #(.NUM_CHAN(NCH), .CH_W(CW)) tcd_table_inst (.*);
	tcd_down #(.CH_W(CW)) tcd_down_inst (.*);
	// Free running clock
	always #5 clk = ~clk;
	// Compare and count
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One command; a spare cycle follows so cmd_valid is never set twice at once
	task issue(input tcd_op_e op, input logic [CW-1:0] ch, input logic pr);
		@(negedge clk);
		cmd_op = op;
		cmd_chan = ch;
		cmd_pri = pr;
		cmd_valid = 1'h1;
		@(negedge clk);
		cmd_valid = 1'h0;
	endtask : issue
	task results;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	// Hang guard
	initial
	begin
		repeat (2000) @(posedge clk);
		bad_count++;
		results();
	end
	// Main sequence: one high list walked through three chains, one low list
	initial
	begin
		{clk, nrst, cmd_valid, cmd_pri, cmd_flag, cmd_chan, cmd_count} = '0;
		{cmd_ptr, cmd_link, cmd_bytes, cmd_addr, cmd_desc_flags} = '0;
		cmd_op = TCD_OP_NONE;
		repeat (4) @(posedge clk);
		@(negedge clk);
		nrst = 1'h1;
		cmd_flag = 1'h1;
		issue(TCD_OP_PROVISION, 3'h1, 1'h1);
		chk("prov", st_provisioned, 1'h1);
		chk("empty", st_nonempty, 1'h0);
		cmd_ptr = 15'h100;
		issue(TCD_OP_APPEND, 3'h2, 1'h1);
		chk("refuse", append_refused, 1'h1);
		issue(TCD_OP_APPEND, 3'h1, 1'h1);
		chk("cur", st_cur_ptr, 15'h100);
		chk("full", st_nonempty, 1'h1);
		cmd_link = 15'h101;
		cmd_bytes = 16'h3;
		cmd_addr = 32'h1000;
		issue(TCD_OP_LOAD, 3'h1, 1'h1);
		chk("host", st_host_ptr, 15'h101);
		chk("flags", st_desc_flags, 4'h0);
		cmd_ptr = 15'h200;
		issue(TCD_OP_APPEND, 3'h1, 1'h1);
		chk("tail", link_tail, 15'h100);
		chk("multi", st_multi_chain, 1'h1);
		chk("next", st_next_ptr, 15'h200);
		cmd_ptr = 15'h300;
		issue(TCD_OP_APPEND, 3'h1, 1'h1);
		chk("tail", link_tail, 15'h200);
		chk("last", st_last_ptr, 15'h300);
		cmd_count = 3'h2;
		issue(TCD_OP_ACCESS, 3'h1, 1'h1);
		chk("bytes", st_bytes, 16'h1);
		chk("addr", st_addr, 32'h1001);
		issue(TCD_OP_ADVANCE, 3'h1, 1'h1);
		chk("stay", st_cur_ptr, 15'h100);
		cmd_count = 3'h1;
		issue(TCD_OP_ACCESS, 3'h1, 1'h1);
		chk("bytes", st_bytes, 16'h0);
		chk("addr", st_addr, 32'h1002);
		issue(TCD_OP_ADVANCE, 3'h1, 1'h1);
		chk("down", st_cur_ptr, 15'h101);
		cmd_ptr = 15'h101;
		cmd_bytes = 16'h0;
		cmd_desc_flags = 4'hf;
		issue(TCD_OP_LOAD, 3'h1, 1'h1);
		chk("flags", st_desc_flags, 4'hf);
		cmd_link = 15'h300;
		issue(TCD_OP_ADVANCE, 3'h1, 1'h1);
		chk("chain2", st_cur_ptr, 15'h200);
		chk("next", st_next_ptr, 15'h300);
		cmd_ptr = 15'h200;
		issue(TCD_OP_LOAD, 3'h1, 1'h1);
		issue(TCD_OP_ADVANCE, 3'h1, 1'h1);
		chk("chain3", st_cur_ptr, 15'h300);
		chk("single", st_multi_chain, 1'h0);
		issue(TCD_OP_REQUEST, 3'h1, 1'h0);
		chk("hi", grant_pri, 1'h1);
		chk("pip", st_in_progress, 1'h1);
		issue(TCD_OP_DONE, 3'h1, 1'h1);
		chk("pip", st_in_progress, 1'h0);
		issue(TCD_OP_PROVISION, 3'h3, 1'h0);
		cmd_ptr = 15'h400;
		issue(TCD_OP_APPEND, 3'h3, 1'h0);
		issue(TCD_OP_REQUEST, 3'h3, 1'h1);
		chk("lo", grant_pri, 1'h0);
		chk("some", grant_empty, 1'h0);
		issue(TCD_OP_MALFORMED, 3'h3, 1'h0);
		issue(TCD_OP_REQUEST, 3'h3, 1'h0);
		chk("null", grant_null_abort, 1'h1);
		tcd_down_inst.flag_und(3'h3, 1'h0);
		issue(TCD_OP_DONE, 3'h3, 1'h0);
		chk("und", st_underflow, 1'h1);
		issue(TCD_OP_FREE, 3'h3, 1'h0);
		chk("und", st_underflow, 1'h0);
		fork
			tcd_down_inst.flag_und(3'h3, 1'h0);
			issue(TCD_OP_FREE, 3'h3, 1'h0);
		join
		chk("und_win", st_underflow, 1'h1);
		issue(TCD_OP_REQUEST, 3'h2, 1'h1);
		chk("none", grant_empty, 1'h1);
		chk("nolo", grant_pri, 1'h0);
		chk("nulls", tcd_down_inst.nulls, 32'h1);
		issue(TCD_OP_REQUEST, 3'h6, 1'h0);
		chk("range", grant_valid, 1'h0);
		cmd_flag = 1'h0;
		issue(TCD_OP_PROVISION, 3'h1, 1'h1);
		chk("off", st_nonempty, 1'h0);
		results();
	end
endmodule : test_tcd_table

bind tcd_table tcd_table_checker #(.NUM_CHAN(NUM_CHAN), .CH_W(CH_W)) tcd_table_checker_inst (.*);
